// [dv/ffmd_tb.sv]
// Self-checking bench for the freefall/motion detector top.
// Assumes the detector built with a short step so strobes come every 10 cycles at rate 0.
`timescale 1ns/1ps
module tb;
  import ffmd_pkg::*;
  // ---------------------------------------------
  // Signals and instance
  // ---------------------------------------------
  localparam int STEP = 10; // Shortened debounce step
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0;
  logic signed [7:0] x = 8'sh00, y = 8'sh00, z = 8'sh00;
  logic [2:0] rate = 3'h0;
  ffmd_os_e os = FFMD_OS_NORMAL;
  logic low_noise = 1'b0, irq_en = 1'b0, irq_route = 1'b0;
  logic irq1, irq2, strobe;
  int n_errors = 0;
  int check_count = 0;
  logic [7:0] v;
  always #5 sys_clk_in = ~sys_clk_in;
  ffmd_top #(.STEP_CYC(STEP), .ACC_W(8)) dut (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .x_accel_in(x),
    .y_accel_in(y), .z_accel_in(z), .sample_rate_in(rate), .os_mode_in(os),
    .low_noise_in(low_noise), .motion_irq_enable_in(irq_en), .motion_irq_route_in(irq_route),
    .irq1_out(irq1), .irq2_out(irq2), .sample_strobe_out(strobe));
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  // Mid-run resets also exercise the asynchronous clear
  task automatic do_reset();
    @(negedge sys_clk_in);
    arst_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
  endtask
  // One-cycle write pulse, a gap cycle after it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge sys_clk_in);
    wr = 1'b0;
  endtask
  // Read data is registered, so it is taken one edge later
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge sys_clk_in);
    rd = 1'b0;
    d = rdata;
  endtask
  // Bounded wait for the next evaluation pulse
  task automatic wait_strobe();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (strobe !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      $display("unexpected strobe wait expected pulse seen none");
      n_errors++;
      report_and_stop();
    end
  endtask
  // Flags land one edge after the pulse, so let that edge pass
  task automatic strobes(input int k);
    repeat (k) wait_strobe();
    @(negedge sys_clk_in);
  endtask
  task automatic src_is(input logic [7:0] exp);
    rd_reg(FFMD_SRC_ADDR, v);
    chk("source", {8'h00, exp}, {8'h00, v});
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  // Reset values, read-only source, reserved config bits, unmapped place
  task automatic t_regs();
    do_reset();
    rd_reg(FFMD_CFG_ADDR, v); chk("cfg reset", 16'h0000, {8'h00, v});
    rd_reg(FFMD_THS_ADDR, v); chk("ths reset", 16'h0000, {8'h00, v});
    rd_reg(FFMD_CNT_ADDR, v); chk("cnt reset", 16'h0000, {8'h00, v});
    rd_reg(8'h20, v); chk("unmapped", 16'h0000, {8'h00, v});
    wr_reg(FFMD_CFG_ADDR, 8'hFF);
    wr_reg(FFMD_SRC_ADDR, 8'hFF);
    wr_reg(FFMD_CNT_ADDR, 8'hA5);
    rd_reg(FFMD_CFG_ADDR, v); chk("cfg rw", 16'h00F8, {8'h00, v});
    rd_reg(FFMD_CNT_ADDR, v); chk("cnt rw", 16'h00A5, {8'h00, v});
    src_is(8'h00);
  endtask
  // Motion walk, saturation, decrement release, strict threshold, irq1
  task automatic t_motion_dec();
    do_reset();
    irq_en = 1'b1;
    irq_route = 1'b1;
    x = 8'sd10;
    y = -8'sd20; // Disabled axis must stay silent
    wr_reg(FFMD_THS_ADDR, 8'h05);
    wr_reg(FFMD_CNT_ADDR, 8'h02);
    wr_reg(FFMD_CFG_ADDR, 8'h48);
    strobes(1); src_is(8'h02);
    chk("irq1 early", 16'h0000, {15'h0000, irq1});
    strobes(1); src_is(8'h82);
    chk("irq1", 16'h0001, {15'h0000, irq1});
    chk("irq2", 16'h0000, {15'h0000, irq2});
    strobes(3);
    x = 8'sd5; // Equal to threshold is not motion
    strobes(1); src_is(8'h80);
    strobes(1); src_is(8'h00);
    chk("irq1 off", 16'h0000, {15'h0000, irq1});
  endtask
  // Clear mode restarts the count, negative polarity
  task automatic t_clear_mode();
    do_reset();
    x = -8'sd10;
    wr_reg(FFMD_THS_ADDR, 8'h85);
    wr_reg(FFMD_CNT_ADDR, 8'h02);
    wr_reg(FFMD_CFG_ADDR, 8'h48);
    rd_reg(FFMD_THS_ADDR, v); chk("ths rw", 16'h0085, {8'h00, v});
    strobes(2); src_is(8'h83);
    x = 8'sd0;
    strobes(1); src_is(8'h00);
    x = -8'sd10;
    strobes(1); src_is(8'h03);
    strobes(1); src_is(8'h83);
  endtask
  // Latched flags freeze and a source read clears them, irq2 route
  task automatic t_latch();
    do_reset();
    irq_en = 1'b1;
    irq_route = 1'b0;
    x = 8'sd10;
    wr_reg(FFMD_THS_ADDR, 8'h05);
    wr_reg(FFMD_CNT_ADDR, 8'h01);
    wr_reg(FFMD_CFG_ADDR, 8'hC8);
    strobes(1);
    chk("irq2", 16'h0001, {15'h0000, irq2});
    x = -8'sd10;
    strobes(1); src_is(8'h82);
    src_is(8'h00);
    chk("irq2 off", 16'h0000, {15'h0000, irq2});
  endtask
  // Freefall AND, disable, low-noise clamp
  task automatic t_freefall();
    do_reset();
    rd_reg(FFMD_CFG_ADDR, v); chk("cfg after reset", 16'h0000, {8'h00, v});
    x = 8'sd5;
    y = -8'sd5;
    z = 8'sd5;
    wr_reg(FFMD_THS_ADDR, 8'h05);
    wr_reg(FFMD_CNT_ADDR, 8'h01);
    wr_reg(FFMD_CFG_ADDR, 8'h38);
    strobes(1); src_is(8'h80);
    z = 8'sd6;
    strobes(1); src_is(8'h20);
    wr_reg(FFMD_CFG_ADDR, 8'h00);
    strobes(1); src_is(8'h00);
    low_noise = 1'b1;
    x = 8'sd70;
    wr_reg(FFMD_THS_ADDR, 8'h64);
    wr_reg(FFMD_CFG_ADDR, 8'h48);
    strobes(1); src_is(8'h82);
    wr_reg(FFMD_CFG_ADDR, 8'h00);
    src_is(8'h00);
  endtask
  // Interval between evaluation pulses for a rate and mode
  task automatic meas(input logic [2:0] r, input ffmd_os_e m, input int mult);
    int n;
    n = 0;
    rate = r;
    os = m;
    wait_strobe();
    wait_strobe();
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (strobe !== 1'b1 && n < 2000);
    chk("strobe period", 16'(STEP * mult), 16'(n));
    if (n >= 2000) begin
      report_and_stop();
    end
  endtask
  task automatic t_period();
    meas(3'h0, FFMD_OS_NORMAL, 1);
    meas(3'h4, FFMD_OS_NORMAL, 16);
    meas(3'h5, FFMD_OS_LOW_POWER_LOW_NOISE, 64);
    meas(3'h7, FFMD_OS_LP, 128);
    meas(3'h4, FFMD_OS_HIRES, 2);
  endtask
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    t_regs();
    t_motion_dec();
    t_clear_mode();
    t_latch();
    t_freefall();
    t_period();
    report_and_stop();
  end
endmodule // tb

// [verilog/ffmd_pkg.sv]
// Shared constants and types for the freefall/motion detector.
// Assumes one 100 MHz system clock and a byte-wide register port.
package ffmd_pkg;
  // ---------------------------------------------
  // Register offsets
  // ---------------------------------------------
  localparam logic [7:0] FFMD_CFG_ADDR = 8'h15; // Config
  localparam logic [7:0] FFMD_SRC_ADDR = 8'h16; // Source, read only
  localparam logic [7:0] FFMD_THS_ADDR = 8'h17; // Threshold
  localparam logic [7:0] FFMD_CNT_ADDR = 8'h18; // Debounce count
  // ---------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------
  localparam int FFMD_THS_MODE_BIT = 7; // Debounce mode bit
  localparam logic [7:0] FFMD_CFG_RST = 8'h00;
  localparam logic [7:0] FFMD_THS_RST = 8'h00;
  localparam logic [7:0] FFMD_CNT_RST = 8'h00;
  // Largest threshold reachable in low-noise mode (4 g)
  localparam logic [6:0] FFMD_THS_LN_MAX = 7'h3F;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int FFMD_CLK_MHZ = 100; // System clock
  localparam int FFMD_STEP_US = 1250; // Base debounce step
  localparam int FFMD_STEP_CYC = FFMD_STEP_US * FFMD_CLK_MHZ;
  // ---------------------------------------------
  // Types
  // ---------------------------------------------
  // Oversampling mode
  typedef enum logic [1:0] {
    FFMD_OS_NORMAL, FFMD_OS_LOW_POWER_LOW_NOISE, FFMD_OS_HIRES, FFMD_OS_LP
  } ffmd_os_e;
  // Configuration register layout
  typedef struct packed {
    logic flag_latch_enable;
    logic motion_or_freefall_choice;
    logic z_event_enable;
    logic y_event_enable;
    logic x_event_enable;
    logic [2:0] zero;
  } ffmd_cfg_s;
  // Source register layout
  typedef struct packed {
    logic event_active_flag;
    logic zero;
    logic z_motion_flag;
    logic z_polarity_flag;
    logic y_motion_flag;
    logic y_polarity_flag;
    logic x_motion_flag;
    logic x_polarity_flag;
  } ffmd_src_s;
endpackage

// [verilog/ffmd_top.sv]
// Freefall/motion detector with its four registers.
// Assumes accel samples in threshold units (0.063 g/count) held stable
// by the sensor path, and a simple synchronous register port.
`timescale 1ns/1ps
module ffmd_top #(
  parameter int STEP_CYC = ffmd_pkg::FFMD_STEP_CYC, // Base step length
  parameter int ACC_W = 8 // Signed sample width
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic signed [ACC_W-1:0] x_accel_in,
  input wire logic signed [ACC_W-1:0] y_accel_in,
  input wire logic signed [ACC_W-1:0] z_accel_in,
  input wire logic [2:0] sample_rate_in,
  input wire ffmd_pkg::ffmd_os_e os_mode_in,
  input wire logic low_noise_in,
  input wire logic motion_irq_enable_in,
  input wire logic motion_irq_route_in,
  output logic irq1_out,
  output logic irq2_out,
  output logic sample_strobe_out
);
  import ffmd_pkg::*;

  // ---------------------------------------------
  // Registers and state
  // ---------------------------------------------
  ffmd_cfg_s motion_config; // Config register
  logic [7:0] motion_threshold; // Mode and threshold
  logic [7:0] motion_debounce_count; // Debounce target
  ffmd_src_s src; // Source flags as stored
  logic ea_flag; // Event-active flop
  logic [5:0] axis_flags; // Motion and polarity flops, z y x
  logic [7:0] dbc; // Debounce counter
  logic [$clog2(STEP_CYC)-1:0] base_cnt; // Base step divider
  logic [7:0] mult_cnt; // Step multiplier count
  logic strobe; // One cycle per sample
  logic src_rd; // Source register read

  // ---------------------------------------------
  // Derived signals
  // ---------------------------------------------
  logic [2:0] en; // Axis enables, z y x
  logic [2:0] hi; // Axis above threshold
  logic [2:0] neg; // Axis sample negative
  logic [6:0] eff_ths; // Threshold after clamp
  logic any_en; // Detector active
  logic cond; // Monitored condition
  logic [7:0] next_dbc; // Counter after this step
  logic [7:0] step_mult; // Steps of 1.25 ms
  logic frozen; // Flags held by latch

  assign en = {motion_config.z_event_enable,
               motion_config.y_event_enable,
               motion_config.x_event_enable};
  assign any_en = |en;
  assign src_rd = reg_rd_in && (reg_addr_in == FFMD_SRC_ADDR);
  assign frozen = motion_config.flag_latch_enable && src.event_active_flag;

  // Low-noise clamp keeps the reachable range at 4 g
  assign eff_ths = (low_noise_in && motion_threshold[6:0] > FFMD_THS_LN_MAX) ?
                   FFMD_THS_LN_MAX : motion_threshold[6:0];

  // ---------------------------------------------
  // Per-axis magnitude compare
  // ---------------------------------------------
  // Threshold counts equal sample counts, so 127 is 8 g
  logic signed [ACC_W-1:0] acc [3];
  assign acc[0] = x_accel_in;
  assign acc[1] = y_accel_in;
  assign acc[2] = z_accel_in;
  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic [ACC_W-1:0] mag; // Absolute value
    assign neg[i] = acc[i][ACC_W-1];
    assign mag = neg[i] ? ACC_W'(-acc[i]) : ACC_W'(acc[i]);
    // Strictly above is motion; at or below is low
    assign hi[i] = mag > ACC_W'(eff_ths);
  end

  // ---------------------------------------------
  // Condition select
  // ---------------------------------------------
  // Disabled axes drop out of both combinations
  always_comb begin
    if (motion_config.motion_or_freefall_choice) begin
      cond = |(en & hi);
    end else begin
      cond = any_en && ((en & hi) == 3'b000);
    end
  end

  // ---------------------------------------------
  // Step length from rate and oversampling
  // ---------------------------------------------
  // Slow rates cap per mode: 20, 80, 2.5, 160 ms
  always_comb begin
    case (sample_rate_in)
      3'h0: step_mult = 8'h01;
      3'h1: step_mult = 8'h02;
      3'h2: step_mult = 8'h04;
      3'h3: step_mult = 8'h08;
      3'h4: step_mult = 8'h10;
      3'h5: step_mult = 8'h40;
      default: step_mult = 8'h80;
    endcase
    case (os_mode_in)
      FFMD_OS_NORMAL: begin
        if (step_mult > 8'h10) step_mult = 8'h10;
      end
      FFMD_OS_LOW_POWER_LOW_NOISE: begin
        if (step_mult > 8'h40) step_mult = 8'h40;
      end
      FFMD_OS_HIRES: begin
        if (step_mult > 8'h02) step_mult = 8'h02;
      end
      default: begin
      end
    endcase
  end

  // ---------------------------------------------
  // Sample strobe divider
  // ---------------------------------------------
  // Rate changes take effect at the next base step
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      base_cnt <= '0;
      mult_cnt <= 8'h00;
      strobe <= 1'b0;
    end else begin
      strobe <= 1'b0;
      if (base_cnt == ($clog2(STEP_CYC))'(STEP_CYC - 1)) begin
        base_cnt <= '0;
        if (mult_cnt + 8'h01 >= step_mult) begin
          mult_cnt <= 8'h00;
          strobe <= 1'b1;
        end else begin
          mult_cnt <= mult_cnt + 8'h01;
        end
      end else begin
        base_cnt <= base_cnt + 1'b1;
      end
    end
  end
  assign sample_strobe_out = strobe;

  // ---------------------------------------------
  // Configuration registers
  // ---------------------------------------------
  // Unused config bits stay zero whatever is written
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      motion_config <= FFMD_CFG_RST;
      motion_threshold <= FFMD_THS_RST;
      motion_debounce_count <= FFMD_CNT_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        FFMD_CFG_ADDR: motion_config <= {reg_wdata_in[7:3], 3'b000};
        FFMD_THS_ADDR: motion_threshold <= reg_wdata_in;
        FFMD_CNT_ADDR: motion_debounce_count <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------
  // Debounce counter
  // ---------------------------------------------
  always_comb begin
    if (cond) begin
      // Never climbs past the target
      next_dbc = (dbc >= motion_debounce_count) ?
                 motion_debounce_count : dbc + 8'h01;
    end else if (motion_threshold[FFMD_THS_MODE_BIT]) begin
      next_dbc = 8'h00;
    end else begin
      next_dbc = (dbc == 8'h00) ? 8'h00 : dbc - 8'h01;
    end
  end

  // Latched read restarts the count so a new event waits again
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dbc <= 8'h00;
    end else if (!any_en) begin
      dbc <= 8'h00;
    end else if (strobe && !frozen) begin
      dbc <= next_dbc;
    end else if (src_rd && motion_config.flag_latch_enable) begin
      dbc <= 8'h00;
    end
  end

  // ---------------------------------------------
  // Event-active flag
  // ---------------------------------------------
  // Setting beats a same-cycle read clear
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ea_flag <= 1'b0;
    end else if (!any_en) begin
      ea_flag <= 1'b0;
    end else if (strobe && cond && next_dbc == motion_debounce_count) begin
      ea_flag <= 1'b1;
    end else if (motion_config.flag_latch_enable) begin
      if (src_rd) begin
        ea_flag <= 1'b0;
      end
    end else if (strobe && !cond &&
                 (motion_threshold[FFMD_THS_MODE_BIT] || next_dbc == 8'h00)) begin
      ea_flag <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Per-axis source flags
  // ---------------------------------------------
  // Raw undebounced view until latched by the event
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      axis_flags <= 6'h00;
    end else if (strobe && !frozen) begin
      axis_flags[5:4] <= {en[2] & hi[2], en[2] & hi[2] & neg[2]};
      axis_flags[3:2] <= {en[1] & hi[1], en[1] & hi[1] & neg[1]};
      axis_flags[1:0] <= {en[0] & hi[0], en[0] & hi[0] & neg[0]};
    end else if (src_rd && motion_config.flag_latch_enable) begin
      axis_flags <= 6'h00;
    end
  end

  // One stored view, bit 6 always zero; separate flops keep one driver each
  assign src = {ea_flag, 1'b0, axis_flags};

  // ---------------------------------------------
  // Read port
  // ---------------------------------------------
  // Source view masks disabled axes at read time
  ffmd_src_s src_view;
  always_comb begin
    src_view = src;
    src_view.zero = 1'b0;
    src_view.z_motion_flag = src.z_motion_flag & en[2];
    src_view.z_polarity_flag = src.z_polarity_flag & en[2];
    src_view.y_motion_flag = src.y_motion_flag & en[1];
    src_view.y_polarity_flag = src.y_polarity_flag & en[1];
    src_view.x_motion_flag = src.x_motion_flag & en[0];
    src_view.x_polarity_flag = src.x_polarity_flag & en[0];
  end

  // Unmapped offsets read as zero
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        FFMD_CFG_ADDR: reg_rdata_out <= motion_config;
        FFMD_SRC_ADDR: reg_rdata_out <= src_view;
        FFMD_THS_ADDR: reg_rdata_out <= motion_threshold;
        FFMD_CNT_ADDR: reg_rdata_out <= motion_debounce_count;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------
  // Interrupt routing
  // ---------------------------------------------
  // Route high selects the first pin
  assign irq1_out = src.event_active_flag & motion_irq_enable_in & motion_irq_route_in;
  assign irq2_out = src.event_active_flag & motion_irq_enable_in & ~motion_irq_route_in;

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  a_disabled_no_flags: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    src_rd && !en[0] |=> reg_rdata_out[1:0] == 2'b00)
    else $error("disabled x axis shows a flag");

  a_counter_saturates: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    strobe && !frozen && any_en |=> dbc <= motion_debounce_count)
    else $error("debounce counter passed its target");

  a_clear_mode_zero: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    strobe && !frozen && any_en && !cond && motion_threshold[FFMD_THS_MODE_BIT] |=> dbc == 8'h00)
    else $error("clear mode did not zero counter");

  a_decrement_step: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    strobe && !frozen && any_en && !cond && !motion_threshold[FFMD_THS_MODE_BIT] && dbc != 8'h00
    |=> dbc == $past(dbc) - 8'h01)
    else $error("decrement mode did not step down by one");

  a_event_on_reach: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    strobe && any_en && cond && next_dbc == motion_debounce_count |=> src.event_active_flag)
    else $error("event flag missed at count");

  a_latch_holds_axes: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    frozen && !src_rd |=> $stable(src[5:0]))
    else $error("latched axis flags changed");

  a_read_clears: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    src_rd && motion_config.flag_latch_enable && !strobe |=> !src.event_active_flag)
    else $error("source read left event flag set");

  a_disable_idle: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    !any_en |=> dbc == 8'h00 && !src.event_active_flag)
    else $error("detector active with no axes");

  a_irq_gating: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    (irq1_out || irq2_out) |-> src.event_active_flag && motion_irq_enable_in)
    else $error("interrupt without enabled event");

  a_ln_clamp: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    low_noise_in && g_axis[0].mag > ACC_W'(FFMD_THS_LN_MAX) |-> hi[0])
    else $error("low-noise threshold above 4 g");
endmodule // ffmd_top
